/* File: host_port_model.sv */
/* host_port_model: host side of the decoded serial port, byte writes and reads.
   assumes the bank samples strobes on the rising edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
    // clock
    input wire logic sys_clk,
    // read answer
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    // requests
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] reg_addr,
    output logic [7:0] wr_data
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        reg_addr = 7'h7f;
        wr_data = 8'h00;
    end
    // released data shows the inverse so a stale byte never looks current
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(posedge sys_clk);
        #2;
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
        @(posedge sys_clk);
        #2;
        reg_addr = a;
        rd_en = 1'b1;
        @(posedge sys_clk);
        #2;
        rd_en = 1'b0;
        ok = rd_valid === 1'b1;
        d = rd_data;
    endtask
endmodule // host_port_model
`default_nettype wire

/* File: lock_aux_driver.sv */
/*
 * lock_aux_driver: auxiliary pin as unlock indicator or routed clock.
 * assumes the pad resolves the output enable.
 */
`timescale 1ns/1ps
`default_nettype none
module lock_aux_driver
(
    // selection
    input wire logic [1:0] auxiliary_source_select,
    input wire logic lock_indicator_driver_config,
    input wire logic aux_disable,
    // sources
    input wire logic pll_locked,
    input wire logic ref_clk_in,
    input wire logic freq_ref_in,
    input wire logic pll_clk_in,
    // pin
    output logic aux_out,
    output logic aux_oe
);
    wire is_lock = auxiliary_source_select == 2'b11;
    wire clk_sel = auxiliary_source_select == 2'b00 ? ref_clk_in :
                   auxiliary_source_select == 2'b01 ? freq_ref_in : pll_clk_in;
    // open drain drives low only when unlocked, floats when locked
    wire lock_oe = lock_indicator_driver_config ? !pll_locked : 1'b1; // RULE7 RULE8 RULE9
    wire lock_val = lock_indicator_driver_config ? 1'b0 : !pll_locked; // RULE8 RULE9
    assign aux_out = is_lock ? lock_val : clk_sel; // RULE7
    assign aux_oe = !aux_disable && (is_lock ? lock_oe : 1'b1);
endmodule // lock_aux_driver
`default_nettype wire

/* File: pll_cfg_defines.svh */
/*
 * register offsets, field positions, reset values and codes for the pll configuration bank.
 * assumes byte-wide registers at 7-bit addresses on the serial port.
 */
`ifndef PLL_CFG_DEFINES_SVH
`define PLL_CFG_DEFINES_SVH

`define ADDR_DEV_CTRL 7'h02
`define ADDR_DEV_CFG1 7'h03
`define ADDR_DEV_CFG2 7'h04
`define ADDR_GLOBAL 7'h05
`define ADDR_RATIO0 7'h06
`define ADDR_RATIO3 7'h09
`define ADDR_FUNC1 7'h16
`define ADDR_FUNC2 7'h17
`define ADDR_FUNC3 7'h1e

`define RESET_BYTE 8'h00

// device control
`define CTRL_UNLOCK_BIT 7
`define CTRL_AUTO_RMOD_BIT 3
`define CTRL_AUX_DIS_BIT 1
`define CTRL_CLK_DIS_BIT 0
`define CTRL_WMASK 8'h0b
// device configuration 1 and 2
`define CFG1_AUX_SRC_LSB 1
`define CFG1_PORT_EN_BIT 0
`define CFG1_WMASK 8'he7
`define CFG2_WMASK 8'h00
// global configuration
`define GLOB_FREEZE_BIT 3
`define GLOB_PORT_EN_BIT 0
`define GLOB_WMASK 8'h09
// function configuration 1..3
`define FUNC1_SKIP_BIT 7
`define FUNC1_LOCK_CFG_BIT 6
`define FUNC1_DIV_LSB 3
`define FUNC1_WMASK 8'hd8
`define FUNC2_UNL_BIT 4
`define FUNC2_FMT_BIT 3
`define FUNC2_WMASK 8'h18
`define FUNC3_BW_LSB 4
`define FUNC3_WMASK 8'h70

`define AUX_SRC_LOCK 2'b11

`endif

/* File: pll_cfg_pkg.sv */
/*
 * types shared by the pll configuration bank.
 * assumes pll_cfg_defines.svh is on the include path.
 */
package pll_cfg_pkg;
    typedef enum logic [1:0] {
        div_by_four,
        div_by_two,
        div_by_one,
        div_reserved
    } ref_div_t;
    typedef logic [7:0] byte_t;
endpackage

/* File: pll_config_register_bank.sv */
/*
 * pll_config_register_bank: byte registers of the clock multiplier, with freeze and port enable.
 * assumes a serial port front end presents decoded byte accesses in sys_clk; pll status is synchronous.
 */
// Function
// RULE1 - freeze holds control/config writes until cleared
// RULE2 - freeze clear: control/config writes act immediately
// RULE3 - port mode needs both enable bits set
// RULE4 - four ratio bytes, first is MSB
// RULE5 - skip enable keeps lock through missing pulses
// RULE6 - host skips only below 80 kHz reference
// RULE7 - lock config applies only for lock source
// RULE8 - config zero: push-pull, high while unlocked
// RULE9 - config one: open drain, low while unlocked
// RULE10 - divider codes 00/01/10 divide 4/2/1
// RULE11 - unlock bit zero: clocks low while unlocked; only clk_out is gated, aux_out passes pll_clk_in ungated on source 2'b10
// RULE12 - unlock bit one: clocks always enabled
// RULE13 - format bit picks 20.12 or 12.20
// RULE14 - bandwidth code doubles from 1 Hz to 128 Hz
// RULE15 - bandwidth change takes effect at acquisition
// RULE16 - host sets bandwidth before enable bits
// RULE17 - port mode needs valid address and enables
// RULE18 - two-wire read/write, four-wire write-only
// RULE19 - host keeps reserved bits at default
// RULE20 - deferred writes apply together on unfreeze
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_defines.svh"
module pll_config_register_bank
    import pll_cfg_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // decoded serial port access
    input wire logic addr_valid,
    input wire logic four_wire_mode,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] reg_addr,
    input wire byte_t wr_data,
    output byte_t rd_data,
    output logic rd_valid,
    // pll status and clocks
    input wire logic pll_locked,
    input wire logic ref_clk_in,
    input wire logic freq_ref_in,
    input wire logic pll_clk_in,
    // control outputs
    output logic control_port_mode,
    output logic pulse_skip_tolerance_enable,
    output ref_div_t timing_reference_divider,
    output logic [2:0] min_loop_bandwidth_select,
    output logic auto_ratio_mod_enable,
    output logic [2:0] ratio_mod_select,
    output logic [31:0] ratio,
    output logic [19:0] ratio_integer,
    output logic [19:0] ratio_fraction,
    output logic ratio_format_select,
    // pins
    output logic clk_out,
    output logic clk_oe,
    output logic aux_out,
    output logic aux_oe
);
    byte_t ctrl_r, cfg1_r, cfg2_r, glob_r, func1_r, func2_r, func3_r;
    byte_t ctrl_act_r, cfg1_act_r, cfg2_act_r;
    byte_t ratio_r [4];
    logic [2:0] bw_act_r;
    logic locked_d_r;

    wire wr_ok = wr_en && addr_valid;
    wire rd_ok = rd_en && addr_valid && !four_wire_mode; // RULE18
    wire wr_ctrl = wr_ok && reg_addr == `ADDR_DEV_CTRL;
    wire wr_cfg1 = wr_ok && reg_addr == `ADDR_DEV_CFG1;
    wire wr_cfg2 = wr_ok && reg_addr == `ADDR_DEV_CFG2;
    wire wr_glob = wr_ok && reg_addr == `ADDR_GLOBAL;
    wire wr_f1 = wr_ok && reg_addr == `ADDR_FUNC1;
    wire wr_f2 = wr_ok && reg_addr == `ADDR_FUNC2;
    wire wr_f3 = wr_ok && reg_addr == `ADDR_FUNC3;
    wire frozen = glob_r[`GLOB_FREEZE_BIT];
    wire byte_t ctrl_nxt = wr_ctrl ? (wr_data & `CTRL_WMASK) : ctrl_r;
    wire byte_t cfg1_nxt = wr_cfg1 ? (wr_data & `CFG1_WMASK) : cfg1_r;
    wire byte_t cfg2_nxt = wr_cfg2 ? (wr_data & `CFG2_WMASK) : cfg2_r;
    // activated copies follow the shadow unless frozen; one load on unfreeze
    wire apply = !frozen; // RULE1 RULE2 RULE20
    wire acquire = pll_locked && !locked_d_r;
    wire [2:0] bw_field = func3_r[`FUNC3_BW_LSB +: 3];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_r <= `RESET_BYTE;
            cfg1_r <= `RESET_BYTE;
            cfg2_r <= `RESET_BYTE;
            glob_r <= `RESET_BYTE;
            func1_r <= `RESET_BYTE;
            func2_r <= `RESET_BYTE;
            func3_r <= `RESET_BYTE;
        end else begin
            ctrl_r <= ctrl_nxt; // RULE1
            cfg1_r <= cfg1_nxt; // RULE1
            cfg2_r <= cfg2_nxt;
            if (wr_glob) glob_r <= wr_data & `GLOB_WMASK;
            if (wr_f1) func1_r <= wr_data & `FUNC1_WMASK;
            if (wr_f2) func2_r <= wr_data & `FUNC2_WMASK;
            if (wr_f3) func3_r <= wr_data & `FUNC3_WMASK;
        end
    end

    // write-through when not frozen, so a write acts in the same edge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_act_r <= `RESET_BYTE;
            cfg1_act_r <= `RESET_BYTE;
            cfg2_act_r <= `RESET_BYTE;
        end else if (apply) begin
            ctrl_act_r <= ctrl_nxt; // RULE2 RULE20
            cfg1_act_r <= cfg1_nxt; // RULE2 RULE20
            cfg2_act_r <= cfg2_nxt; // RULE2 RULE20
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ratio
            always_ff @(posedge sys_clk) begin
                if (!resetn) ratio_r[gi] <= `RESET_BYTE;
                else if (wr_ok && reg_addr == `ADDR_RATIO0 + 7'(gi)) ratio_r[gi] <= wr_data;
            end
        end
    endgenerate

    // bandwidth latched when unlocked or at lock acquisition, not while locked
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bw_act_r <= 3'h0;
            locked_d_r <= 1'b0;
        end else begin
            locked_d_r <= pll_locked;
            if (!pll_locked || acquire) bw_act_r <= bw_field; // RULE14 RULE15
        end
    end

    // read mux, unmapped reads return zero
    wire byte_t status_byte = ctrl_r | (byte_t'(!pll_locked) << `CTRL_UNLOCK_BIT);
    wire in_ratio = reg_addr >= `ADDR_RATIO0 && reg_addr <= `ADDR_RATIO3;
    wire [1:0] ratio_idx = 2'(reg_addr - `ADDR_RATIO0);
    wire byte_t rd_mux =
        reg_addr == `ADDR_DEV_CTRL ? status_byte :
        reg_addr == `ADDR_DEV_CFG1 ? cfg1_r :
        reg_addr == `ADDR_DEV_CFG2 ? cfg2_r :
        reg_addr == `ADDR_GLOBAL ? glob_r :
        reg_addr == `ADDR_FUNC1 ? func1_r :
        reg_addr == `ADDR_FUNC2 ? func2_r :
        reg_addr == `ADDR_FUNC3 ? func3_r :
        in_ratio ? ratio_r[ratio_idx] : `RESET_BYTE;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rd_data <= `RESET_BYTE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_ok; // RULE18
            if (rd_ok) rd_data <= rd_mux;
        end
    end

    // port mode is a combination of the two enable bits and the address match
    assign control_port_mode = addr_valid && cfg1_act_r[`CFG1_PORT_EN_BIT] &&
                               glob_r[`GLOB_PORT_EN_BIT]; // RULE3 RULE17
    // skip tolerance only forwarded; reference rate limit is the host's duty
    assign pulse_skip_tolerance_enable = func1_r[`FUNC1_SKIP_BIT]; // RULE5
    assign timing_reference_divider = ref_div_t'(func1_r[`FUNC1_DIV_LSB +: 2]); // RULE10
    assign min_loop_bandwidth_select = bw_act_r; // RULE14
    assign auto_ratio_mod_enable = ctrl_act_r[`CTRL_AUTO_RMOD_BIT];
    assign ratio_mod_select = cfg1_act_r[7:5];
    assign ratio_format_select = func2_r[`FUNC2_FMT_BIT];

    wire unl_en = func2_r[`FUNC2_UNL_BIT];
    assign clk_out = (unl_en || pll_locked) ? pll_clk_in : 1'b0; // RULE11 RULE12
    assign clk_oe = !ctrl_act_r[`CTRL_CLK_DIS_BIT];

    ratio_assembler u_ratio (
        .b0(ratio_r[0]),
        .b1(ratio_r[1]),
        .b2(ratio_r[2]),
        .b3(ratio_r[3]),
        .ratio_format_select(ratio_format_select),
        .ratio(ratio),
        .ratio_integer(ratio_integer),
        .ratio_fraction(ratio_fraction)
    );

    lock_aux_driver u_aux (
        .auxiliary_source_select(cfg1_act_r[`CFG1_AUX_SRC_LSB +: 2]),
        .lock_indicator_driver_config(func1_r[`FUNC1_LOCK_CFG_BIT]),
        .aux_disable(ctrl_act_r[`CTRL_AUX_DIS_BIT]),
        .pll_locked(pll_locked),
        .ref_clk_in(ref_clk_in),
        .freq_ref_in(freq_ref_in),
        .pll_clk_in(pll_clk_in),
        .aux_out(aux_out),
        .aux_oe(aux_oe)
    );

    property p_freeze_hold;
        @(posedge sys_clk) disable iff (!resetn)
        frozen && $past(frozen) |-> $stable(cfg1_act_r);
    endproperty
    a_freeze_hold: assert property (p_freeze_hold) else $error("config changed while frozen"); // RULE1

    property p_direct_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_cfg1 && !frozen |=> cfg1_act_r == $past(wr_data & `CFG1_WMASK);
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("unfrozen write not applied"); // RULE2

    property p_unfreeze_all;
        @(posedge sys_clk) disable iff (!resetn)
        // a write landing on the unfreeze edge belongs to the same load
        frozen ##1 !frozen |=> ctrl_act_r == $past(ctrl_nxt) && cfg1_act_r == $past(cfg1_nxt);
    endproperty
    a_unfreeze_all: assert property (p_unfreeze_all) else $error("deferred writes not applied together"); // RULE20

    property p_port_mode;
        @(posedge sys_clk) disable iff (!resetn)
        control_port_mode |-> cfg1_act_r[0] && glob_r[0] && addr_valid;
    endproperty
    a_port_mode: assert property (p_port_mode) else $error("port mode without both enables"); // RULE3

    property p_ratio_order;
        @(posedge sys_clk) disable iff (!resetn)
        wr_ok && reg_addr == `ADDR_RATIO0 |=> ratio[31:24] == $past(wr_data);
    endproperty
    a_ratio_order: assert property (p_ratio_order) else $error("first ratio byte not most significant"); // RULE4

    property p_clk_low_unlocked;
        @(posedge sys_clk) disable iff (!resetn)
        !unl_en && !pll_locked |-> !clk_out;
    endproperty
    a_clk_low_unlocked: assert property (p_clk_low_unlocked) else $error("clock out while unlocked"); // RULE11

    property p_pushpull_unlock;
        @(posedge sys_clk) disable iff (!resetn)
        cfg1_act_r[2:1] == `AUX_SRC_LOCK && !func1_r[6] && !ctrl_act_r[1] |-> aux_oe && aux_out == !pll_locked;
    endproperty
    a_pushpull_unlock: assert property (p_pushpull_unlock) else $error("push-pull lock level wrong"); // RULE8

    property p_opendrain;
        @(posedge sys_clk) disable iff (!resetn)
        cfg1_act_r[2:1] == `AUX_SRC_LOCK && func1_r[6] |-> !aux_out && (aux_oe -> !pll_locked);
    endproperty
    a_opendrain: assert property (p_opendrain) else $error("open drain drove while locked"); // RULE9

    property p_bw_locked;
        @(posedge sys_clk) disable iff (!resetn)
        // the acquisition edge may still take a field written one edge before it
        pll_locked && $past(pll_locked) && $past(pll_locked, 2) |-> $stable(bw_act_r);
    endproperty
    a_bw_locked: assert property (p_bw_locked) else $error("bandwidth changed while locked"); // RULE15

    property p_spi_no_read;
        @(posedge sys_clk) disable iff (!resetn)
        four_wire_mode && rd_en |=> !rd_valid;
    endproperty
    a_spi_no_read: assert property (p_spi_no_read) else $error("read answered in four-wire mode"); // RULE18

    // an accepted read is answered on the very next edge, never later
    property p_read_answer;
        @(posedge sys_clk) disable iff (!resetn)
        rd_ok |=> rd_valid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("accepted read not answered"); // RULE18

    property p_bw_unlocked;
        @(posedge sys_clk) disable iff (!resetn)
        !pll_locked |=> min_loop_bandwidth_select == $past(bw_field);
    endproperty
    a_bw_unlocked: assert property (p_bw_unlocked) else $error("bandwidth not taken while unlocked"); // RULE14 RULE15

    property p_skip_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_f1 |=> pulse_skip_tolerance_enable == $past(wr_data[`FUNC1_SKIP_BIT]);
    endproperty
    a_skip_write: assert property (p_skip_write) else $error("skip enable not taken from write"); // RULE5

    property p_div_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_f1 |=> timing_reference_divider == ref_div_t'($past(wr_data[`FUNC1_DIV_LSB +: 2]));
    endproperty
    a_div_write: assert property (p_div_write) else $error("divider code not taken from write"); // RULE10

    property p_fmt_write;
        @(posedge sys_clk) disable iff (!resetn)
        wr_f2 |=> ratio_format_select == $past(wr_data[`FUNC2_FMT_BIT]);
    endproperty
    a_fmt_write: assert property (p_fmt_write) else $error("ratio format not taken from write"); // RULE13

    property p_clk_always;
        @(posedge sys_clk) disable iff (!resetn)
        unl_en |-> clk_out == pll_clk_in;
    endproperty
    a_clk_always: assert property (p_clk_always) else $error("clock gated although always enabled"); // RULE12

    // with the pll clock routed out (source 2'b10), the lock driver setting must not matter
    property p_aux_clock;
        @(posedge sys_clk) disable iff (!resetn)
        cfg1_act_r[`CFG1_AUX_SRC_LSB +: 2] == 2'b10 |->
            aux_out == pll_clk_in && aux_oe == !ctrl_act_r[`CTRL_AUX_DIS_BIT];
    endproperty
    a_aux_clock: assert property (p_aux_clock) else $error("routed clock disturbed by lock setting"); // RULE7

    c_freeze_cycle: cover property (@(posedge sys_clk) disable iff (!resetn) frozen ##1 wr_cfg1 ##[1:20] !frozen);
    c_port_mode: cover property (@(posedge sys_clk) disable iff (!resetn) control_port_mode);
    c_relock: cover property (@(posedge sys_clk) disable iff (!resetn) !pll_locked ##1 pll_locked);
    c_read: cover property (@(posedge sys_clk) disable iff (!resetn) rd_valid);
    c_lock_release: cover property (@(posedge sys_clk) disable iff (!resetn)
        cfg1_act_r[2:1] == `AUX_SRC_LOCK && func1_r[6] && pll_locked && !aux_oe);
endmodule // pll_config_register_bank
`default_nettype wire

/* File: pll_config_register_bank_tb.sv */
/* pll_config_register_bank_tb: bank against a byte-level model of its registers.
   assumes host_port_model drives the access port and pll status is set here. */
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_defines.svh"
module pll_config_register_bank_tb
    import pll_cfg_pkg::*;
;
    logic sys_clk, resetn, addr_valid, four_wire_mode, wr_en, rd_en, rd_valid, pll_locked;
    logic ref_clk_in, freq_ref_in, pll_clk_in, control_port_mode, pulse_skip_tolerance_enable;
    logic auto_ratio_mod_enable, ratio_format_select, clk_out, clk_oe, aux_out, aux_oe, frz;
    logic [6:0] reg_addr;
    byte_t wr_data, rd_data, a2, a3;
    ref_div_t timing_reference_divider;
    logic [2:0] min_loop_bandwidth_select, ratio_mod_select, bwm;
    logic [31:0] ratio;
    logic [19:0] ratio_integer, ratio_fraction;
    logic [7:0] m [128];
    int n_mismatch, n_checks, cyc;
    pll_config_register_bank pll_config_register_bank_i (.sys_clk(sys_clk), .resetn(resetn),
        .addr_valid(addr_valid), .four_wire_mode(four_wire_mode), .wr_en(wr_en), .rd_en(rd_en),
        .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .pll_locked(pll_locked), .ref_clk_in(ref_clk_in), .freq_ref_in(freq_ref_in),
        .pll_clk_in(pll_clk_in), .control_port_mode(control_port_mode),
        .pulse_skip_tolerance_enable(pulse_skip_tolerance_enable),
        .timing_reference_divider(timing_reference_divider),
        .min_loop_bandwidth_select(min_loop_bandwidth_select),
        .auto_ratio_mod_enable(auto_ratio_mod_enable), .ratio_mod_select(ratio_mod_select),
        .ratio(ratio), .ratio_integer(ratio_integer), .ratio_fraction(ratio_fraction),
        .ratio_format_select(ratio_format_select), .clk_out(clk_out), .clk_oe(clk_oe),
        .aux_out(aux_out), .aux_oe(aux_oe));
    host_port_model host_port_model_i (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] wmask(input logic [6:0] a);
        case (a)
            `ADDR_DEV_CTRL: return `CTRL_WMASK;
            `ADDR_DEV_CFG1: return `CFG1_WMASK;
            `ADDR_GLOBAL: return `GLOB_WMASK;
            `ADDR_FUNC1: return `FUNC1_WMASK;
            `ADDR_FUNC2: return `FUNC2_WMASK;
            `ADDR_FUNC3: return `FUNC3_WMASK;
            default: return (a >= `ADDR_RATIO0 && a <= `ADDR_RATIO3) ? 8'hff : 8'h00;
        endcase
    endfunction
    // the model follows every accepted write; bandwidth only moves while unlocked
    task automatic mw(input logic [6:0] a, input logic [7:0] d);
        if (wmask(a) != 8'h00) d = d & wmask(a);
        host_port_model_i.wr(a, d);
        if (addr_valid) begin
            m[a] = d & wmask(a);
            if (a == `ADDR_GLOBAL) frz = m[a][3];
            if (!frz) {a2, a3} = {m[2], m[3]};
            if (!pll_locked) bwm = m[7'h1e][6:4];
        end
        repeat (2) @(posedge sys_clk);
        #2;
    endtask
    task automatic set_lock(input logic v);
        if (!v || !pll_locked) bwm = m[7'h1e][6:4];
        pll_locked = v;
        repeat (2) @(posedge sys_clk);
        #2;
    endtask
    task automatic rdchk(input logic [6:0] a);
        logic [7:0] d;
        bit ok;
        host_port_model_i.rd(a, d, ok);
        chk(ok, four_wire_mode ? 0 : 1);
        if (ok) chk(d, a == 7'h02 ? m[2] | {!pll_locked, 7'h00} : m[a]);
    endtask
    task automatic chk_out;
        int s;
        logic e, o;
        {ref_clk_in, pll_clk_in} = 2'($urandom);
        if (!m[7'h16][7]) freq_ref_in = 1'($urandom);
        #1;
        s = a3[2:1];
        e = s == 0 ? ref_clk_in : s == 1 ? freq_ref_in : s == 2 ? pll_clk_in : !m[7'h16][6] & !pll_locked;
        o = (s == 3 && m[7'h16][6]) ? !pll_locked : 1'b1;
        chk(control_port_mode, addr_valid & a3[0] & m[5][0]);
        chk({ratio_mod_select, auto_ratio_mod_enable}, {a3[7:5], a2[3]});
        chk(pulse_skip_tolerance_enable, m[7'h16][7]);
        chk(timing_reference_divider, m[7'h16][4:3]);
        chk(min_loop_bandwidth_select, bwm);
        chk(ratio, {m[6], m[7], m[8], m[9]});
        chk(ratio_integer, m[7'h17][3] ? {8'h00, m[6], m[7][7:4]} : {m[6], m[7], m[8][7:4]});
        chk(ratio_fraction, m[7'h17][3] ? {m[7][3:0], m[8], m[9]} : {m[8][3:0], m[9], 8'h00});
        chk({clk_oe, clk_out}, {!a2[0], (m[7'h17][4] | pll_locked) & pll_clk_in});
        chk({aux_oe, aux_out}, {o & !a2[1], e});
    endtask
    initial begin
        logic [6:0] adr [11];
        adr = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h09, 7'h16, 7'h17, 7'h1e};
        {resetn, addr_valid, four_wire_mode, pll_locked, frz, a2, a3, bwm} = 0;
        {ref_clk_in, freq_ref_in, pll_clk_in, n_mismatch, n_checks, cyc} = 0;
        foreach (m[i]) m[i] = 8'h00;
        void'($urandom(43));
        repeat (12) @(posedge sys_clk);
        #2 resetn = 1'b1;
        addr_valid = 1'b1;
        foreach (adr[i]) rdchk(adr[i]);
        chk_out;
        mw(7'h1e, 8'h50);
        mw(7'h03, 8'h01);
        chk_out;
        mw(7'h05, 8'h01);
        chk_out;
        addr_valid = 1'b0;
        chk_out;
        mw(7'h16, 8'hff);
        addr_valid = 1'b1;
        rdchk(7'h16);
        repeat (4) begin
            mw(7'h02, 8'($urandom));
            mw(7'h03, 8'($urandom) | 8'h01);
            chk_out;
            rdchk(7'h02);
        end
        mw(7'h05, 8'h09);
        mw(7'h02, 8'($urandom));
        mw(7'h03, 8'($urandom) | 8'h01);
        chk_out;
        rdchk(7'h03);
        mw(7'h05, 8'h01);
        chk_out;
        for (int f = 0; f < 2; f++) begin
            mw(7'h17, 8'(f << 3));
            for (int b = 6; b < 10; b++) mw(7'(b), 8'($urandom));
            chk_out;
        end
        for (int c = 0; c < 4; c++) begin
            mw(7'h16, (8'($urandom) & 8'he7) | 8'(c << 3));
            chk_out;
        end
        for (int c = 0; c < 8; c++) begin
            mw(7'h1e, 8'(c << 4) | 8'h8f);
            chk_out;
        end
        set_lock(1'b1);
        mw(7'h1e, 8'h20);
        chk_out;
        set_lock(1'b0);
        chk_out;
        mw(7'h02, 8'h00);
        for (int i = 0; i < 16; i++) begin
            mw(7'h03, {5'h00, i[3] ? 2'b11 : 2'(i), 1'b1});
            mw(7'h16, {1'b0, i[0], 6'h00});
            mw(7'h17, {3'h0, i[1], 4'h0});
            set_lock(i[2]);
            chk_out;
        end
        four_wire_mode = 1'b1;
        rdchk(7'h16);
        four_wire_mode = 1'b0;
        mw(7'h10, 8'hff);
        rdchk(7'h10);
        complete_run;
    end
endmodule // pll_config_register_bank_tb
`default_nettype wire

/* File: ratio_assembler.sv */
/*
 * ratio_assembler: joins four ratio bytes, first address most significant, and splits integer/fraction.
 * assumes bytes arrive from the register bank.
 */
`timescale 1ns/1ps
`default_nettype none
module ratio_assembler
    import pll_cfg_pkg::*;
(
    // ratio bytes, index 0 at the lowest address
    input wire byte_t b0,
    input wire byte_t b1,
    input wire byte_t b2,
    input wire byte_t b3,
    // format
    input wire logic ratio_format_select,
    // results
    output logic [31:0] ratio,
    output logic [19:0] ratio_integer,
    output logic [19:0] ratio_fraction
);
    assign ratio = {b0, b1, b2, b3}; // RULE4
    // fraction is left aligned so both formats share one width
    assign ratio_integer = ratio_format_select ? {8'h00, ratio[31:20]} : ratio[31:12]; // RULE13
    assign ratio_fraction = ratio_format_select ? ratio[19:0] : {ratio[11:0], 8'h00}; // RULE13
endmodule // ratio_assembler
`default_nettype wire
